// ==== lsogr_regs.sv ====
// led switch override, short status and group membership registers
// assumes the serial slave presents decoded single-cycle read/write strobes
//
// Functional notes
// - each of 12 override bits holds its channel's bypass switch closed
// - an overridden channel has zero on-time regardless of duty or fade
// - with override bit clear the switch follows normal dimming control
// - faults are evaluated only while the switch is open
// - 12-bit short status, bit set when a shorted lamp is detected
// - reading short status returns it then clears it; writes ignored
// - group members take group phase, fade and duty writes; others not
// - group A mask at 0x0A, select code 0001 and its duty register
// - group B mask at 0x0B, select code 0010 and its duty register
// - group C mask at 0x0C, select code 0100 and its duty register
// - group D mask at 0x0D, select code 1000 and its duty register
// - group phase write copies 4-bit phase to all selected groups' channels
// - group phase write with select 0000 changes no channel's phase; the select and value are still stored
// - fault mask bit stops that channel's faults reaching the fault output
`timescale 1ns/1ps
module lsogr_regs
  import lsogr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [CH_N-1:0] dim_on,
  input wire logic [CH_N-1:0] open_evt,
  input wire logic [CH_N-1:0] short_evt,
  input wire logic [CH_N-1:0] trace_evt,
  output logic [DATA_W-1:0] reg_rdata_r,
  output logic [CH_N-1:0] switch_closed,
  output logic [CH_N-1:0] led_on,
  output logic fault_out_n_r,
  output logic [CH_N*PH_W-1:0] phase_value_r,
  output logic [CH_N-1:0] fade_load_r,
  output logic [CH_N-1:0] duty_load_r,
  output logic [DATA_W-1:0] load_data_r
);
  logic [CH_N-1:0] force_closed_bits_r;
  logic [CH_N-1:0] short_detect_bits_r;
  logic [CH_N-1:0] grp_r [GRP_N];
  logic [CH_N-1:0] fault_mask_bits_r;
  logic [3:0] phase_group_select_r;
  logic [3:0] phase_val_r;
  logic [CH_N-1:0] short_seen;
  logic [CH_N-1:0] fault_hit;
  logic [CH_N-1:0] ph_hit;
  logic [CH_N-1:0] fade_hit;
  logic [CH_N-1:0] duty_hit;
  logic [3:0] ph_sel;
  logic [3:0] fade_sel;
  logic [3:0] duty_sel;
  logic ph_wr;
  logic [DATA_W-1:0] rd_mux;

  // ------------------------------------------------------------
  // channel slices
  // ------------------------------------------------------------
  for (genvar i = 0; i < CH_N; i++) begin : g_ch
    lsogr_chan u_chan (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .force_closed(force_closed_bits_r[i]),
      .dim_on(dim_on[i]),
      .open_evt(open_evt[i]),
      .short_evt(short_evt[i]),
      .trace_evt(trace_evt[i]),
      .fault_mask(fault_mask_bits_r[i]),
      .switch_closed_r(switch_closed[i]),
      .led_on_r(led_on[i]),
      .short_seen(short_seen[i]),
      .fault_hit(fault_hit[i])
    );
    // a channel answers when any selected group lists it
    assign ph_hit[i] = |(ph_sel & {grp_r[3][i], grp_r[2][i], grp_r[1][i], grp_r[0][i]});
    assign fade_hit[i] = |(fade_sel & {grp_r[3][i], grp_r[2][i], grp_r[1][i], grp_r[0][i]});
    assign duty_hit[i] = |(duty_sel & {grp_r[3][i], grp_r[2][i], grp_r[1][i], grp_r[0][i]});

    always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
        phase_value_r[i*PH_W +: PH_W] <= PH_VAL_RST;
      end else if (clk_en && ph_wr && ph_hit[i]) begin
        phase_value_r[i*PH_W +: PH_W] <= reg_wdata[PH_VAL_LSB +: PH_W];
      end
    end
  end

  // ------------------------------------------------------------
  // group write decode
  // ------------------------------------------------------------
  assign ph_wr = reg_wr && (reg_addr == OFS_GROUP_PHASE);
  assign ph_sel = ph_wr ? reg_wdata[PH_SEL_LSB +: 4] : SEL_NONE;
  assign fade_sel = (reg_wr && reg_addr == OFS_GROUP_FADE) ?
                    reg_wdata[FADE_SEL_LSB +: 4] : SEL_NONE;
  always_comb begin
    duty_sel = SEL_NONE;
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_DUTY_A: duty_sel = 4'h1;
        OFS_DUTY_B: duty_sel = 4'h2;
        OFS_DUTY_C: duty_sel = 4'h4;
        OFS_DUTY_D: duty_sel = 4'h8;
        default: duty_sel = SEL_NONE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      fade_load_r <= CH_RST;
      duty_load_r <= CH_RST;
      load_data_r <= RD_ZERO;
    end else if (clk_en) begin
      fade_load_r <= fade_hit;
      duty_load_r <= duty_hit;
      if (reg_wr) begin
        load_data_r <= reg_wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      force_closed_bits_r <= CH_RST;
      fault_mask_bits_r <= CH_RST;
      phase_group_select_r <= PH_SEL_RST;
      phase_val_r <= PH_VAL_RST;
      for (int g = 0; g < GRP_N; g++) begin
        grp_r[g] <= CH_RST;
      end
    end else if (clk_en && reg_wr) begin
      // upper data bits are simply not stored
      unique case (reg_addr)
        OFS_FORCE_CLOSED: force_closed_bits_r <= reg_wdata[CH_N-1:0];
        OFS_GROUP_A: grp_r[0] <= reg_wdata[CH_N-1:0];
        OFS_GROUP_B: grp_r[1] <= reg_wdata[CH_N-1:0];
        OFS_GROUP_C: grp_r[2] <= reg_wdata[CH_N-1:0];
        OFS_GROUP_D: grp_r[3] <= reg_wdata[CH_N-1:0];
        OFS_FAULT_MASK: fault_mask_bits_r <= reg_wdata[CH_N-1:0];
        OFS_GROUP_PHASE: begin
          phase_group_select_r <= reg_wdata[PH_SEL_LSB +: 4];
          phase_val_r <= reg_wdata[PH_VAL_LSB +: 4];
        end
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // short status, clear on read
  // ------------------------------------------------------------
  // a short seen in the read cycle survives the clear, so none is lost
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      short_detect_bits_r <= CH_RST;
    end else if (clk_en) begin
      if (reg_rd && reg_addr == OFS_SHORT_STATUS) begin
        short_detect_bits_r <= short_seen;
      end else begin
        short_detect_bits_r <= short_detect_bits_r | short_seen;
      end
    end
  end

  // ------------------------------------------------------------
  // fault output
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      fault_out_n_r <= 1'b1;
    end else if (clk_en) begin
      fault_out_n_r <= ~(|(short_detect_bits_r & ~fault_mask_bits_r) | |fault_hit);
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  always_comb begin
    rd_mux = RD_ZERO;
    unique case (reg_addr)
      OFS_FORCE_CLOSED: rd_mux = {4'h0, force_closed_bits_r};
      OFS_SHORT_STATUS: rd_mux = {4'h0, short_detect_bits_r};
      OFS_GROUP_A: rd_mux = {4'h0, grp_r[0]};
      OFS_GROUP_B: rd_mux = {4'h0, grp_r[1]};
      OFS_GROUP_C: rd_mux = {4'h0, grp_r[2]};
      OFS_GROUP_D: rd_mux = {4'h0, grp_r[3]};
      OFS_FAULT_MASK: rd_mux = {4'h0, fault_mask_bits_r};
      OFS_GROUP_PHASE: rd_mux = {8'h00, phase_group_select_r, phase_val_r};
      default: rd_mux = RD_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      reg_rdata_r <= RD_ZERO;
    end else if (clk_en && reg_rd) begin
      reg_rdata_r <= rd_mux;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  status_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && reg_rd && reg_addr == OFS_SHORT_STATUS && short_seen == CH_RST)
    |=> short_detect_bits_r == CH_RST)
    else $error("short status not cleared by read");
  status_return_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && reg_rd && reg_addr == OFS_SHORT_STATUS)
    |=> reg_rdata_r == {4'h0, $past(short_detect_bits_r)})
    else $error("short status read returned wrong value");
  status_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && !(reg_rd && reg_addr == OFS_SHORT_STATUS))
    |=> (short_detect_bits_r & $past(short_detect_bits_r | short_seen))
        == $past(short_detect_bits_r | short_seen))
    else $error("short status bit lost");
  phase_none_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ph_wr && reg_wdata[PH_SEL_LSB +: 4] == SEL_NONE) |=> $stable(phase_value_r))
    else $error("phase changed on empty group select");
  phase_copy_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && ph_wr && ph_hit[0]) |=> phase_value_r[3:0] == $past(reg_wdata[3:0]))
    else $error("selected channel missed group phase");
  duty_member_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && reg_wr && reg_addr == OFS_DUTY_A) |=> duty_load_r == $past(grp_r[0]))
    else $error("group A duty load mismatch");
  mask_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && reg_wr && reg_addr == OFS_GROUP_B)
    ##1 !reg_wr
    ##1 (clk_en && reg_rd && reg_addr == OFS_GROUP_B && !reg_wr)
    |=> reg_rdata_r == {4'h0, $past(reg_wdata[CH_N-1:0], 3)})
    else $error("membership readback wrong");
  fault_masked_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && fault_mask_bits_r == 12'hFFF) |=> fault_out_n_r)
    else $error("masked fault reached output");
endmodule : lsogr_regs

// ==== lsogr_pkg.sv ====
// constants for the led switch override and group register bank
// assumes a decoded register port from the serial slave, one device clock
package lsogr_pkg;
  localparam int CH_N = 12;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int PH_W = 4;
  localparam int GRP_N = 4;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_FORCE_CLOSED = 8'h08;
  localparam logic [7:0] OFS_SHORT_STATUS = 8'h09;
  localparam logic [7:0] OFS_GROUP_A = 8'h0A;
  localparam logic [7:0] OFS_GROUP_B = 8'h0B;
  localparam logic [7:0] OFS_GROUP_C = 8'h0C;
  localparam logic [7:0] OFS_GROUP_D = 8'h0D;
  localparam logic [7:0] OFS_FAULT_MASK = 8'h0E;
  localparam logic [7:0] OFS_GROUP_PHASE = 8'h10;
  localparam logic [7:0] OFS_GROUP_FADE = 8'h34;
  localparam logic [7:0] OFS_DUTY_A = 8'h30;
  localparam logic [7:0] OFS_DUTY_B = 8'h31;
  localparam logic [7:0] OFS_DUTY_C = 8'h32;
  localparam logic [7:0] OFS_DUTY_D = 8'h33;
  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int PH_VAL_LSB = 0;
  localparam int PH_SEL_LSB = 4;
  localparam int FADE_SEL_LSB = 12;
  localparam logic [3:0] PH_SEL_RST = 4'h1;
  localparam logic [3:0] PH_VAL_RST = 4'h0;
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [11:0] CH_RST = 12'h000;
  localparam logic [15:0] RD_ZERO = 16'h0000;
endpackage : lsogr_pkg

// ==== lsogr_chan.sv ====
// one channel slice: switch drive and fault qualification
// assumes dim_on comes from the channel's normal dimming engine
`timescale 1ns/1ps
module lsogr_chan
  import lsogr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic force_closed,
  input wire logic dim_on,
  input wire logic open_evt,
  input wire logic short_evt,
  input wire logic trace_evt,
  input wire logic fault_mask,
  output logic switch_closed_r,
  output logic led_on_r,
  output logic short_seen,
  output logic fault_hit
);
  logic sw_open;

  // ------------------------------------------------------------
  // switch drive
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      switch_closed_r <= 1'b1;
      led_on_r <= 1'b0;
    end else if (clk_en) begin
      switch_closed_r <= force_closed | ~dim_on;
      led_on_r <= ~force_closed & dim_on;
    end
  end

  // faults only count while the switch really stands open
  assign sw_open = ~switch_closed_r & ~force_closed;
  assign short_seen = sw_open & short_evt;
  assign fault_hit = sw_open & ~fault_mask & (open_evt | short_evt | trace_evt);

  force_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && force_closed) |=> switch_closed_r)
    else $error("forced channel switch not closed");
  zero_on_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && force_closed) |=> !led_on_r)
    else $error("forced channel shows on-time");
  normal_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && !force_closed) |=> (switch_closed_r == !$past(dim_on)))
    else $error("unforced switch does not follow dimming");
  no_fault_forced_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    force_closed |-> !fault_hit && !short_seen)
    else $error("forced channel raised a fault");
endmodule : lsogr_chan

// ==== lsogr_host.sv ====
// serial master stand-in: issues decoded register strobes
// assumes the slave takes a strobe on the sys_clk rising edge
`timescale 1ns/1ps
module lsogr_host
  import lsogr_pkg::*;
(
  input wire logic sys_clk,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata_r
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // ------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------
  // idle lines show the inverse, so a stale value is never mistaken
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata_r;
  endtask : rd
endmodule : lsogr_host

// ==== tb_top.sv ====
// self-checking bench for the override, short status and group registers
// assumes the host model drives the register strobes
`timescale 1ns/1ps
module tb_top
  import lsogr_pkg::*;
();
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic [11:0] dim_on = 12'hFFF;
  logic [11:0] open_evt = 12'h000;
  logic [11:0] short_evt = 12'h000;
  logic [11:0] trace_evt = 12'h000;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata_r, load_data_r, d;
  logic reg_wr, reg_rd, fault_out_n_r;
  logic [11:0] switch_closed, led_on, fade_load_r, duty_load_r;
  logic [47:0] phase_value_r, pe;
  logic [3:0] ph_exp [12];
  logic [7:0] ofs [5] = '{8'h08, 8'h0A, 8'h0B, 8'h0C, 8'h0D};
  logic [11:0] val [5] = '{12'hA5A, 12'h0C3, 12'h306, 12'h830, 12'h408};
  logic [3:0] sel [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h0};
  int n_fail = 0;
  int n_checks = 0;
  always #2 sys_clk = ~sys_clk;
  lsogr_host host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r));
  lsogr_regs dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .dim_on(dim_on),
    .open_evt(open_evt), .short_evt(short_evt), .trace_evt(trace_evt),
    .reg_rdata_r(reg_rdata_r), .switch_closed(switch_closed), .led_on(led_on),
    .fault_out_n_r(fault_out_n_r), .phase_value_r(phase_value_r),
    .fade_load_r(fade_load_r), .duty_load_r(duty_load_r), .load_data_r(load_data_r));
  // ------------------------------------------------------------
  // compare and close
  // ------------------------------------------------------------
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic pulse_short(input logic [11:0] s);
    @(posedge sys_clk);
    #1;
    short_evt = s;
    @(posedge sys_clk);
    #1;
    short_evt = 12'h000;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : pulse_short
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    foreach (ph_exp[i]) ph_exp[i] = 4'h0;
    repeat (5) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    for (int i = 0; i < 5; i++) begin
      host.rd(ofs[i], d);
      chk(d, 0);
      host.wr(ofs[i], {4'hF, val[i]});
      host.rd(ofs[i], d);
      chk(d, {4'h0, val[i]});
    end
    repeat (2) @(posedge sys_clk);
    #1;
    chk(switch_closed, 12'hA5A);
    chk(led_on, 12'h5A5);
    dim_on = 12'h0F0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(switch_closed, 12'hF5F);
    chk(led_on, 12'h0A0);
    dim_on = 12'hFFF;
    // channel 1 is forced, so its short must not be recorded
    pulse_short(12'h007);
    chk(fault_out_n_r, 0);
    host.wr(OFS_SHORT_STATUS, 16'h0FFF);
    host.rd(OFS_SHORT_STATUS, d);
    chk(d, 16'h0005);
    host.rd(OFS_SHORT_STATUS, d);
    chk(d, 16'h0000);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(fault_out_n_r, 1);
    host.wr(OFS_FAULT_MASK, 16'h0005);
    pulse_short(12'h005);
    chk(fault_out_n_r, 1);
    host.rd(OFS_SHORT_STATUS, d);
    chk(d, 16'h0005);
    // channel 7 reports an open lamp until the controller overrides it
    open_evt = 12'h080;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(fault_out_n_r, 0);
    host.wr(OFS_FORCE_CLOSED, 16'h0ADA);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(fault_out_n_r, 1);
    open_evt = 12'h000;
    // every channel masked: live open and trace events stay silent
    host.wr(OFS_FAULT_MASK, 16'h0FFF);
    open_evt = 12'hFFF;
    trace_evt = 12'hFFF;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(fault_out_n_r, 1);
    open_evt = 12'h000;
    trace_evt = 12'h000;
    // a write while the clock enable is low must not land
    clk_en = 1'b0;
    host.wr(OFS_FORCE_CLOSED, 16'h0FFF);
    clk_en = 1'b1;
    host.rd(OFS_FORCE_CLOSED, d);
    chk(d, 16'h0ADA);
    for (int k = 0; k < 6; k++) begin
      host.wr(OFS_GROUP_PHASE, {8'h00, sel[k], 4'(k + 5)});
      for (int c = 0; c < 12; c++) begin
        for (int g = 0; g < 4; g++) if (sel[k][g] && val[g+1][c]) ph_exp[c] = 4'(k + 5);
        pe[4*c +: 4] = ph_exp[c];
      end
      chk(phase_value_r, pe);
    end
    for (int g = 0; g < 4; g++) begin
      host.wr(OFS_DUTY_A + 8'(g), 16'h0AB0 + 16'(g));
      chk(duty_load_r, val[g+1]);
      chk(load_data_r, 16'h0AB0 + 16'(g));
    end
    host.wr(OFS_GROUP_FADE, 16'h5123);
    chk(fade_load_r, val[1] | val[3]);
    print_verdict();
  end
  initial begin
    #(4 * 3000);
    n_fail++;
    print_verdict();
  end
endmodule : tb_top
